/* verilog/dtr_tuning_regs.vh */
// register offsets, field positions, reset values and timing counts of the tuning bank
`ifndef DTR_TUNING_REGS_VH
`define DTR_TUNING_REGS_VH

`define DTR_OFS_NCO_MID       8'h22
`define DTR_OFS_NCO_LOW       8'h23
`define DTR_OFS_GAIN_HIGH     8'h24
`define DTR_OFS_GAIN_LOW      8'h25
`define DTR_OFS_STRENGTH      8'h26
`define DTR_OFS_CLEAR_LEVEL   8'h27
`define DTR_OFS_ANT_ONE       8'h28
`define DTR_OFS_ANT_TWO       8'h29
`define DTR_OFS_FREQ_LIMIT    8'h2A
`define DTR_OFS_FERR_HIGH     8'h2B
`define DTR_OFS_CNT_HIGH      8'h2C
`define DTR_OFS_CNT_LOW       8'h2D
`define DTR_OFS_IRQ_STATUS    8'hE0
`define DTR_OFS_IRQ_MASK      8'hE1

`define DTR_RST_NCO_MID       8'h00
`define DTR_RST_NCO_LOW       8'hAE
`define DTR_RST_GAIN_HIGH     3'h2
`define DTR_RST_GAIN_LOW      8'h00
`define DTR_RST_STRENGTH      8'h00
`define DTR_RST_CLEAR_LEVEL   8'h1E
`define DTR_RST_ANT           8'h00
`define DTR_RST_FREQ_LIMIT    8'h2A
`define DTR_RST_FERR          10'h0AC
`define DTR_RST_CNT_CTRL      3'h5
`define DTR_RST_CNT_HIGH      3'h4
`define DTR_RST_CNT_LOW       8'h00
`define DTR_RST_IRQ           2'h0

`define DTR_BIT_FREEZE        5
`define DTR_BIT_PEAK          4
`define DTR_BIT_AVG           3
`define DTR_IRQ_CLEAR_CHAN    0
`define DTR_IRQ_FERR_DONE     1
`define DTR_IRQ_WIDTH         2

`define DTR_CLK_PERIOD_NS     50
`define DTR_REF_PERIOD_NS     2000
`define DTR_REF_DIV           (`DTR_REF_PERIOD_NS / `DTR_CLK_PERIOD_NS)

`endif

/* verilog/dtr_demod_regs.v */
// demodulator tuning and measurement register bank with clear-channel interrupt
//
// The strobed register port was chosen for this implementation.
`include "dtr_tuning_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block and its host do
// RQ1 - hold 20-bit NCO offset bits 15:8 and 7:0, low byte resets to AEh
// RQ2 - host computes NCO offset from data rate and decimation, programs all bits; here only bits 15:0 have registers
// RQ3 - hold 11-bit timing loop gain split 3 plus 8 bits, high resets 02h
// RQ4 - host programs timing loop gain from Manchester, data rate, oversampling, deviation
// RQ5 - present 8-bit read-only signal strength; writes have no effect
// RQ6 - raise clear-channel condition when strength exceeds threshold, threshold resets 1Eh
// RQ7 - report antenna 1 and antenna 2 strength in two read-only registers
// RQ8 - hold 8-bit frequency correction limit, resetting to 2Ah
// RQ9 - expose 10-bit correction result, updated once per reception after sync
// RQ10 - hold 11-bit on-off keying counter split over two registers
// RQ11 - host programs counter from 500 kHz, data rate and Manchester enable
// RQ12 - counter is 11 bits; lower data rates would overflow it
// RQ13 - counter-high bit 5 freezes on-off keying gain control
// RQ14 - bit 4 enables peak detector, bit 3 enables moving-average block
// RQ15 - correction-result high resets 2Bh, counter-high resets 2Ch
// RQ16 - writes to reserved or read-only bits are ignored
module dtr_demod_regs (
    CORE_CLK,
    ARST_N,
    REG_ADDR,
    REG_WDATA,
    REG_WR,
    REG_RD,
    REG_RDATA,
    STRENGTH_IN,
    STRENGTH_VLD,
    ANT_ONE_IN,
    ANT_ONE_VLD,
    ANT_TWO_IN,
    ANT_TWO_VLD,
    RX_START,
    FERR_IN,
    SYNC_FOUND,
    NCO_OFFSET,
    TIMING_GAIN,
    FREQ_LIMIT,
    ONOFF_COUNT,
    ONOFF_TICK,
    ONOFF_AGC_FREEZE,
    PEAK_DET_EN,
    AVG_DET_EN,
    CLEAR_CHANNEL,
    IRQ
);
    input  wire        CORE_CLK;
    input  wire        ARST_N;
    input  wire [7:0]  REG_ADDR;
    input  wire [7:0]  REG_WDATA;
    input  wire        REG_WR;
    input  wire        REG_RD;
    output reg  [7:0]  REG_RDATA;
    input  wire [7:0]  STRENGTH_IN;
    input  wire        STRENGTH_VLD;
    input  wire [7:0]  ANT_ONE_IN;
    input  wire        ANT_ONE_VLD;
    input  wire [7:0]  ANT_TWO_IN;
    input  wire        ANT_TWO_VLD;
    input  wire        RX_START;
    input  wire [9:0]  FERR_IN;
    input  wire        SYNC_FOUND;
    output wire [15:0] NCO_OFFSET;
    output wire [10:0] TIMING_GAIN;
    output wire [7:0]  FREQ_LIMIT;
    output wire [10:0] ONOFF_COUNT;
    output reg         ONOFF_TICK;
    output wire        ONOFF_AGC_FREEZE;
    output wire        PEAK_DET_EN;
    output wire        AVG_DET_EN;
    output reg         CLEAR_CHANNEL;
    output reg         IRQ;

    ////////////////////////////////////////////////////////////////////////////
    // register state

    reg  [7:0]  nco_mid_q;
    reg  [7:0]  nco_low_q;
    reg  [2:0]  gain_high_q;
    reg  [7:0]  gain_low_q;
    reg  [7:0]  strength_q;
    reg  [7:0]  clear_level_q;
    reg  [7:0]  ant_one_q;
    reg  [7:0]  ant_two_q;
    reg  [7:0]  freq_limit_q;
    reg  [9:0]  ferr_q;
    reg         ferr_armed_q;
    reg  [2:0]  cnt_ctrl_q;
    reg  [2:0]  cnt_high_q;
    reg  [7:0]  cnt_low_q;
    reg  [`DTR_IRQ_WIDTH-1:0] irq_status_q;
    reg  [`DTR_IRQ_WIDTH-1:0] irq_mask_q;
    reg  [7:0]  rdata_d;
    reg  [5:0]  ref_cnt_q;
    reg         ref_tick_q;
    reg  [10:0] ook_cnt_q;

    wire        wr_nco_mid;
    wire        wr_nco_low;
    wire        wr_gain_high;
    wire        wr_gain_low;
    wire        wr_clear_level;
    wire        wr_freq_limit;
    wire        wr_cnt_high;
    wire        wr_cnt_low;
    wire        wr_irq_status;
    wire        wr_irq_mask;
    wire        over_level;
    wire        ferr_capture;
    wire [`DTR_IRQ_WIDTH-1:0] irq_event;

    assign wr_nco_mid     = REG_WR && (REG_ADDR == `DTR_OFS_NCO_MID);
    assign wr_nco_low     = REG_WR && (REG_ADDR == `DTR_OFS_NCO_LOW);
    assign wr_gain_high   = REG_WR && (REG_ADDR == `DTR_OFS_GAIN_HIGH);
    assign wr_gain_low    = REG_WR && (REG_ADDR == `DTR_OFS_GAIN_LOW);
    assign wr_clear_level = REG_WR && (REG_ADDR == `DTR_OFS_CLEAR_LEVEL);
    assign wr_freq_limit  = REG_WR && (REG_ADDR == `DTR_OFS_FREQ_LIMIT);
    assign wr_cnt_high    = REG_WR && (REG_ADDR == `DTR_OFS_CNT_HIGH);
    assign wr_cnt_low     = REG_WR && (REG_ADDR == `DTR_OFS_CNT_LOW);
    assign wr_irq_status  = REG_WR && (REG_ADDR == `DTR_OFS_IRQ_STATUS);
    assign wr_irq_mask    = REG_WR && (REG_ADDR == `DTR_OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // software-written settings

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            nco_mid_q     <= `DTR_RST_NCO_MID;
            nco_low_q     <= `DTR_RST_NCO_LOW;
            gain_high_q   <= `DTR_RST_GAIN_HIGH;
            gain_low_q    <= `DTR_RST_GAIN_LOW;
            clear_level_q <= `DTR_RST_CLEAR_LEVEL;
            freq_limit_q  <= `DTR_RST_FREQ_LIMIT;
            cnt_ctrl_q    <= `DTR_RST_CNT_CTRL;
            cnt_high_q    <= `DTR_RST_CNT_HIGH;
            cnt_low_q     <= `DTR_RST_CNT_LOW;
            irq_mask_q    <= `DTR_RST_IRQ;
        end else begin
            if (wr_nco_mid) begin
                nco_mid_q <= REG_WDATA;                              // RQ1
            end
            if (wr_nco_low) begin
                nco_low_q <= REG_WDATA;                              // RQ1
            end
            // bits 7:3 are reserved and never stored
            if (wr_gain_high) begin
                gain_high_q <= REG_WDATA[2:0];                       // RQ3 RQ16
            end
            if (wr_gain_low) begin
                gain_low_q <= REG_WDATA;                             // RQ3
            end
            if (wr_clear_level) begin
                clear_level_q <= REG_WDATA;                          // RQ6
            end
            if (wr_freq_limit) begin
                freq_limit_q <= REG_WDATA;                           // RQ8
            end
            // bits 7:6 carry the correction result and are not writable
            if (wr_cnt_high) begin
                cnt_ctrl_q <= REG_WDATA[`DTR_BIT_FREEZE:`DTR_BIT_AVG];  // RQ13 RQ14 RQ16
                cnt_high_q <= REG_WDATA[2:0];                        // RQ10
            end
            if (wr_cnt_low) begin
                cnt_low_q <= REG_WDATA;                              // RQ10
            end
            if (wr_irq_mask) begin
                irq_mask_q <= REG_WDATA[`DTR_IRQ_WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurements from the demodulator; the bus cannot write any of these

    assign ferr_capture = SYNC_FOUND && ferr_armed_q;

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            strength_q   <= `DTR_RST_STRENGTH;
            ant_one_q    <= `DTR_RST_ANT;
            ant_two_q    <= `DTR_RST_ANT;
            ferr_q       <= `DTR_RST_FERR;
            ferr_armed_q <= 1'b0;
        end else begin
            if (STRENGTH_VLD) begin
                strength_q <= STRENGTH_IN;                           // RQ5
            end
            if (ANT_ONE_VLD) begin
                ant_one_q <= ANT_ONE_IN;                             // RQ7
            end
            if (ANT_TWO_VLD) begin
                ant_two_q <= ANT_TWO_IN;                             // RQ7
            end
            // a second sync in the same reception must not overwrite the result
            if (ferr_capture) begin
                ferr_q <= FERR_IN;                                   // RQ9
            end
            if (RX_START) begin
                ferr_armed_q <= 1'b1;                                // RQ9
            end else if (ferr_capture) begin
                ferr_armed_q <= 1'b0;                                // RQ9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear-channel detection and interrupt status

    assign over_level = strength_q > clear_level_q;                  // RQ6

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CLEAR_CHANNEL <= 1'b0;
        end else begin
            CLEAR_CHANNEL <= over_level;                             // RQ6
        end
    end

    // only the rising edge is an event, so a steady strong signal interrupts once
    assign irq_event[`DTR_IRQ_CLEAR_CHAN] = over_level && !CLEAR_CHANNEL;  // RQ6
    assign irq_event[`DTR_IRQ_FERR_DONE]  = ferr_capture;

    genvar gi;
    generate
        for (gi = 0; gi < `DTR_IRQ_WIDTH; gi = gi + 1) begin : g_irq
            // a new event beats a write-one-to-clear in the same cycle
            always @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    irq_status_q[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_status_q[gi] <= 1'b1;
                end else if (wr_irq_status && REG_WDATA[gi]) begin
                    irq_status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // on-off keying bit period counter, stepped by a 500 kHz enable

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ref_cnt_q  <= 6'h00;
            ref_tick_q <= 1'b0;
        end else if (ref_cnt_q == (`DTR_REF_DIV - 1)) begin
            ref_cnt_q  <= 6'h00;
            ref_tick_q <= 1'b1;
        end else begin
            ref_cnt_q  <= ref_cnt_q + 6'h01;
            ref_tick_q <= 1'b0;
        end
    end

    // 11 bits of 500 kHz ticks bound the slowest bit period; a slower rate wraps
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ook_cnt_q  <= 11'h000;
            ONOFF_TICK <= 1'b0;
        end else if (ref_tick_q) begin
            if (ook_cnt_q == 11'h000) begin
                ook_cnt_q  <= {cnt_high_q, cnt_low_q};               // RQ10 RQ12
                ONOFF_TICK <= 1'b1;
            end else begin
                ook_cnt_q  <= ook_cnt_q - 11'h001;                   // RQ12
                ONOFF_TICK <= 1'b0;
            end
        end else begin
            ONOFF_TICK <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings driven to the demodulator

    assign NCO_OFFSET       = {nco_mid_q, nco_low_q};                // RQ1
    assign TIMING_GAIN      = {gain_high_q, gain_low_q};             // RQ3
    assign FREQ_LIMIT       = freq_limit_q;                          // RQ8
    assign ONOFF_COUNT      = {cnt_high_q, cnt_low_q};               // RQ10
    assign ONOFF_AGC_FREEZE = cnt_ctrl_q[2];                         // RQ13
    assign PEAK_DET_EN      = cnt_ctrl_q[1];                         // RQ14
    assign AVG_DET_EN       = cnt_ctrl_q[0];                         // RQ14

    ////////////////////////////////////////////////////////////////////////////
    // read port: data stand one cycle after the strobe, zero elsewhere

    always @* begin
        rdata_d = 8'h00;
        case (REG_ADDR)
            `DTR_OFS_NCO_MID: begin
                rdata_d = nco_mid_q;
            end
            `DTR_OFS_NCO_LOW: begin
                rdata_d = nco_low_q;
            end
            `DTR_OFS_GAIN_HIGH: begin
                rdata_d = {5'h00, gain_high_q};                      // RQ16
            end
            `DTR_OFS_GAIN_LOW: begin
                rdata_d = gain_low_q;
            end
            `DTR_OFS_STRENGTH: begin
                rdata_d = strength_q;                                // RQ5
            end
            `DTR_OFS_CLEAR_LEVEL: begin
                rdata_d = clear_level_q;
            end
            `DTR_OFS_ANT_ONE: begin
                rdata_d = ant_one_q;                                 // RQ7
            end
            `DTR_OFS_ANT_TWO: begin
                rdata_d = ant_two_q;                                 // RQ7
            end
            `DTR_OFS_FREQ_LIMIT: begin
                rdata_d = freq_limit_q;
            end
            `DTR_OFS_FERR_HIGH: begin
                rdata_d = ferr_q[9:2];                               // RQ9 RQ15
            end
            `DTR_OFS_CNT_HIGH: begin
                rdata_d = {ferr_q[1:0], cnt_ctrl_q, cnt_high_q};     // RQ9 RQ15
            end
            `DTR_OFS_CNT_LOW: begin
                rdata_d = cnt_low_q;
            end
            `DTR_OFS_IRQ_STATUS: begin
                rdata_d = {6'h00, irq_status_q};
            end
            `DTR_OFS_IRQ_MASK: begin
                rdata_d = {6'h00, irq_mask_q};
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_d;
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

endmodule // dtr_demod_regs

/* tb/dtr_demod_monitor.sv */
// concurrent checks on the ports of the tuning register bank
module dtr_demod_monitor (
    input wire logic        CORE_CLK,
    input wire logic        ARST_N,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_RDATA,
    input wire logic [7:0]  STRENGTH_IN,
    input wire logic        STRENGTH_VLD,
    input wire logic [15:0] NCO_OFFSET,
    input wire logic [10:0] TIMING_GAIN,
    input wire logic [7:0]  FREQ_LIMIT,
    input wire logic [10:0] ONOFF_COUNT,
    input wire logic        ONOFF_AGC_FREEZE,
    input wire logic        PEAK_DET_EN,
    input wire logic        AVG_DET_EN,
    input wire logic        CLEAR_CHANNEL
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] str_q;
    logic [7:0] thr_q;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);
    ////////////////////////////////////////////////////////////////////////////////
    // mirrors of strength and threshold, so the compare needs no internal probes
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            str_q <= 8'h00;
            thr_q <= 8'h1E;
        end else begin
            str_q <= STRENGTH_VLD ? STRENGTH_IN : str_q;
            thr_q <= (REG_WR && REG_ADDR == 8'h27) ? REG_WDATA : thr_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_nco_mid_write: assert property (
        REG_WR && REG_ADDR == 8'h22 |=> NCO_OFFSET[15:8] == $past(REG_WDATA))
        else $error("nco mid byte not loaded from write");
    a_nco_low_write: assert property (
        REG_WR && REG_ADDR == 8'h23 |=> NCO_OFFSET[7:0] == $past(REG_WDATA))
        else $error("nco low byte not loaded from write");
    a_gain_high_bits: assert property (
        REG_WR && REG_ADDR == 8'h24 |=> TIMING_GAIN[10:8] == $past(REG_WDATA[2:0]))
        else $error("gain top bits not loaded from write");
    a_limit_write: assert property (
        REG_WR && REG_ADDR == 8'h2A |=> FREQ_LIMIT == $past(REG_WDATA))
        else $error("limit not loaded from write");
    a_counter_ctrl_bits: assert property (
        REG_WR && REG_ADDR == 8'h2C |=> {ONOFF_AGC_FREEZE, PEAK_DET_EN, AVG_DET_EN,
        ONOFF_COUNT[10:8]} == $past(REG_WDATA[5:0]))
        else $error("counter high controls not loaded from write");
    a_strength_read: assert property (
        REG_RD && REG_ADDR == 8'h26 |=> REG_RDATA == $past(str_q))
        else $error("strength read does not match loaded value");
    a_clear_level: assert property (
        CLEAR_CHANNEL == ($past(str_q) > $past(thr_q)))
        else $error("clear channel level wrong");
    a_read_data_idle: assert property (
        !REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data not idle after no read");
endmodule // dtr_demod_monitor

bind dtr_demod_regs dtr_demod_monitor mon (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .STRENGTH_IN(STRENGTH_IN),
    .STRENGTH_VLD(STRENGTH_VLD), .NCO_OFFSET(NCO_OFFSET), .TIMING_GAIN(TIMING_GAIN),
    .FREQ_LIMIT(FREQ_LIMIT), .ONOFF_COUNT(ONOFF_COUNT), .ONOFF_AGC_FREEZE(ONOFF_AGC_FREEZE),
    .PEAK_DET_EN(PEAK_DET_EN), .AVG_DET_EN(AVG_DET_EN), .CLEAR_CHANNEL(CLEAR_CHANNEL)
);

/* tb/dtr_host_model.sv */
// host model driving the register bus of the tuning bank
module dtr_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr = 8'h00,
    output logic      [7:0] reg_wdata = 8'h00,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobes last one cycle; a new call always lets an edge pass first
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    function automatic logic [10:0] onoff_val(input int rb_khz, input int manch);
        return 11'(1500 / (rb_khz * (1 + manch)));
    endfunction
    // 20-bit offset from data rate, Manchester, decimation exponent and divide-by-three bypass
    function automatic logic [19:0] nco_val(input longint rb_kbps, input longint manch,
                                            input longint ndec, input longint dwn3);
        return 20'((rb_kbps * (1 + manch) * (longint'(1) << (20 + ndec))) /
                   (500 * (1 + 2 * dwn3)));
    endfunction
    // oversampling ratio is given in eighths, as the hardware holds it with a 3-bit fraction
    function automatic logic [10:0] gain_val(input longint rb_kbps, input longint manch,
                                             input longint osr8, input longint fd_khz);
        return 11'(2 + (32768 * (1 + manch) * rb_kbps * 8) / (osr8 * fd_khz));
    endfunction
endmodule // dtr_host_model

/* tb/dtr_demod_regs_test.sv */
// self-checking bench of the tuning register bank
`include "dtr_tuning_regs.vh"
module dtr_demod_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk;
    logic        arst_n;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, strength_in, ant_one_in, ant_two_in;
    logic        reg_wr, reg_rd, strength_vld, ant_one_vld, ant_two_vld, rx_start, sync_found;
    logic [9:0]  ferr_in;
    logic [15:0] nco_offset;
    logic [10:0] timing_gain, onoff_count;
    logic [7:0]  freq_limit;
    logic        onoff_tick, agc_freeze, peak_en, avg_en, clear_chan, irq;
    int          n_fail = 0;
    int          tests_run = 0;

    dtr_demod_regs dut (
        .CORE_CLK(core_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .STRENGTH_IN(strength_in),
        .STRENGTH_VLD(strength_vld), .ANT_ONE_IN(ant_one_in), .ANT_ONE_VLD(ant_one_vld),
        .ANT_TWO_IN(ant_two_in), .ANT_TWO_VLD(ant_two_vld), .RX_START(rx_start),
        .FERR_IN(ferr_in), .SYNC_FOUND(sync_found), .NCO_OFFSET(nco_offset),
        .TIMING_GAIN(timing_gain), .FREQ_LIMIT(freq_limit), .ONOFF_COUNT(onoff_count),
        .ONOFF_TICK(onoff_tick), .ONOFF_AGC_FREEZE(agc_freeze), .PEAK_DET_EN(peak_en),
        .AVG_DET_EN(avg_en), .CLEAR_CHANNEL(clear_chan), .IRQ(irq)
    );
    dtr_host_model host (
        .clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd_reg(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task automatic load(input int sel, input logic [7:0] v);
        @(posedge core_clk);
        {strength_in, ant_one_in, ant_two_in} <= {v, v, v};
        {ant_two_vld, ant_one_vld, strength_vld} <= 3'(1 << sel);
        @(posedge core_clk);
        {ant_two_vld, ant_one_vld, strength_vld} <= 3'h0;
    endtask
    task automatic mark(input logic [1:0] rs, input logic [9:0] f);
        @(posedge core_clk);
        {rx_start, sync_found} <= rs;
        ferr_in <= f;
        @(posedge core_clk);
        {rx_start, sync_found} <= 2'h0;
    endtask
    task automatic wait_tick(input int lim, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (onoff_tick !== 1'b1 && n < lim);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] rv [12];
        rv = '{8'h00, 8'hAE, 8'h02, 8'h00, 8'h00, 8'h1E, 8'h00, 8'h00, 8'h2A, 8'h2B, 8'h2C, 8'h00};
        chk(nco_offset, 16'h00AE);
        chk({5'h00, timing_gain}, 16'h0200);
        chk({5'h00, onoff_count}, 16'h0400);
        chk({13'h0000, agc_freeze, peak_en, avg_en}, 16'h0005);
        for (int i = 0; i < 12; i++) rchk(8'h22 + 8'(i), rv[i]);
    endtask
    task automatic t_access();
        logic [7:0] fv [12];
        fv = '{8'hFF, 8'hFF, 8'h07, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h2B, 8'h3F, 8'hFF};
        for (int i = 0; i < 12; i++) host.wr_reg(8'h22 + 8'(i), 8'hFF);
        for (int i = 0; i < 12; i++) rchk(8'h22 + 8'(i), fv[i]);
        rchk(8'h30, 8'h00);
        chk({5'h00, onoff_count}, 16'h07FF);
        chk({13'h0000, agc_freeze, peak_en, avg_en}, 16'h0007);
        chk({freq_limit, 8'h00}, 16'hFF00);
        for (int i = 0; i < 12; i++) host.wr_reg(8'h22 + 8'(i), 8'h00);
        for (int i = 0; i < 12; i++) rchk(8'h22 + 8'(i), (i == 9) ? 8'h2B : 8'h00);
        chk({5'h00, timing_gain}, 16'h0000);
        chk({13'h0000, agc_freeze, peak_en, avg_en}, 16'h0000);
    endtask
    task automatic t_strength();
        host.wr_reg(8'h27, 8'h1E);
        host.wr_reg(`DTR_OFS_IRQ_MASK, 8'h01);
        load(0, 8'h1E);
        repeat (3) @(posedge core_clk);
        #1;
        chk({14'h0000, clear_chan, irq}, 16'h0000);
        load(0, 8'h1F);
        repeat (3) @(posedge core_clk);
        #1;
        chk({14'h0000, clear_chan, irq}, 16'h0003);
        rchk(`DTR_OFS_IRQ_STATUS, 8'h01);
        host.wr_reg(`DTR_OFS_IRQ_STATUS, 8'h01);
        @(posedge core_clk);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        host.wr_reg(8'h26, 8'h00);
        load(1, 8'h33);
        load(2, 8'h44);
        rchk(8'h29, 8'h44);
        rchk(8'h28, 8'h33);
        rchk(8'h26, 8'h1F);
    endtask
    task automatic t_ferr();
        mark(2'h2, 10'h2B5);
        mark(2'h1, 10'h2B5);
        rchk(8'h2B, 8'hAD);
        rchk(8'h2C, 8'h40);
        // a second sync in the same reception must not overwrite the result
        mark(2'h1, 10'h155);
        rchk(8'h2B, 8'hAD);
        rchk(`DTR_OFS_IRQ_STATUS, 8'h02);
    endtask
    task automatic t_tick();
        logic [10:0] cnt;
        int          gap;
        logic [19:0] nco;
        logic [10:0] gn;
        cnt = host.onoff_val(40, 0);
        nco = host.nco_val(40, 0, 0, 0);
        gn = host.gain_val(2, 0, 100, 40);
        host.wr_reg(8'h22, nco[15:8]);
        host.wr_reg(8'h23, nco[7:0]);
        host.wr_reg(8'h24, {5'h00, gn[10:8]});
        host.wr_reg(8'h25, gn[7:0]);
        host.wr_reg(8'h2C, {5'h00, cnt[10:8]});
        host.wr_reg(8'h2D, cnt[7:0]);
        // let the last write settle before looking at the outputs
        #1;
        chk(nco_offset, 16'h47AE);
        chk({5'h00, timing_gain}, 16'h0085);
        chk({5'h00, onoff_count}, 16'h0025);
        // the reset count still runs out first, since reload waits for terminal count
        wait_tick(45000, gap);
        chk({15'h0000, onoff_tick}, 16'h0001);
        wait_tick(2000, gap);
        chk(16'(gap), 16'((cnt + 1) * `DTR_REF_DIV));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        close_out();
    end
    initial begin
        arst_n = 1'b0;
        {strength_vld, ant_one_vld, ant_two_vld, rx_start, sync_found} = 5'h00;
        {strength_in, ant_one_in, ant_two_in, ferr_in} = 34'h0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_access();
        t_strength();
        t_ferr();
        t_tick();
        close_out();
    end
endmodule // dtr_demod_regs_test
